// file: rtl/usb_role_select_pkg.sv
// Constants for the role select and port watch block
// Assumes one 125 MHz clock and an AXI4-Lite register slave
package usb_role_select_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ROLE_SEL_OFS = 8'h00;
  localparam logic [7:0] PM_MON_OFS = 8'h04;
  localparam logic [7:0] TOP_STAT_OFS = 8'h08;
  localparam logic [7:0] TOP_EN_OFS = 8'h0C;
  localparam logic [7:0] PERI_STAT_OFS = 8'h10;
  localparam logic [7:0] PERI_EN_OFS = 8'h14;
  localparam logic [7:0] PERI_USB_OFS = 8'h18;
  localparam logic [7:0] HOST_STAT_OFS = 8'h20;
  localparam logic [7:0] HOST_EN_OFS = 8'h24;
  localparam logic [7:0] HOST_XCVR_OFS = 8'h28;
  localparam logic [7:0] HOST_USBCTL_OFS = 8'h2C;
  localparam logic [7:0] HOST_USBSTAT_OFS = 8'h30;
  localparam logic [7:0] HOST_NEGO_OFS = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MAP_SEL_BIT = 0;
  localparam int PORT_CNT_BIT = 1;
  localparam int ACT_ROLE_BIT = 0;
  localparam int DEV_SUM_BIT = 0;
  localparam int HOST_SUM_BIT = 1;
  localparam int SUP_CHG_BIT = 0;
  localparam int LINE_CHG_BIT = 0;
  localparam int FAULT_BIT = 1;
  localparam int SENSE_BIT = 0;
  localparam int PWR_EN_BIT = 0;
  localparam int FAULT_LVL_BIT = 2;

  // Pin order inside the synchroniser
  localparam int PIN_SENSE = 0;
  localparam int PIN_FAULT_N = 1;
  localparam int PIN_DP = 2;
  localparam int PIN_DM = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] XCVR_RST = 8'h00;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic [3:0] PIN_RST = 4'h0;
  localparam logic [1:0] WARM_DONE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power-management states
  typedef enum logic [2:0] {
    SLEEP_ST, DOZE_ST, OSC_ACTIVE_ST, PERIPH_ACTIVE_ST, HOSTSIDE_ACTIVE_ST, BOTH_ACTIVE_ST
  } pm_state_t;

endpackage

// file: rtl/usb_role_select_port_watch.sv
// Role map select, function select and USB port watch with AXI4-Lite registers
// Assumes pmState comes from logic on ref_clk; port pins are asynchronous
//
// Overview of operation
// - map-select bit: 1 host map, 0 device
// - shared registers always; role registers only mapped
// - map-select writable in every power state
// - 2-port mode: function follows power state
// - monitor bit shows active function, 1 host
// - 1-port mode: function follows map-select bit
// - port watch runs in every state, role
// - supply sense pin change sets supply flag
// - supply enable gates device summary bit
// - supply sense level readable, 1 powered
// - either data line change sets line flag
// - line and fault enables gate host summary
// - fault pin error sets supply fault flag
// - power-enable bit drives power switch pin
// - fault pin level readable as status bit
// - line condition readable as 2-bit field
// - 2-bit field sets transceiver operating mode
// - transceiver and power kept, nonzero code in host role updates them
`timescale 1ns/1ps
module usb_role_select_port_watch
  import usb_role_select_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Power management
  input pm_state_t pmState,
  input wire logic bothEntryHost,
  // Port pins
  input wire logic supplySensePin,
  input wire logic faultPin_n,
  input wire logic dpPin,
  input wire logic dmPin,
  output logic hostPowerEnable,
  output logic [7:0] hostXcvrCtrl,
  output logic [1:0] transceiverOpField,
  // Role and summary
  output logic roleMapSelect,
  output logic portCountSelect,
  output logic activeRoleMonitor,
  output logic deviceFunctionEnable,
  output logic hostFunctionEnable,
  output logic deviceIrqSummary,
  output logic hostIrqSummary,
  output logic mainIrq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic mapSel;
    logic portCount;
    logic [1:0] topEn;
    logic supChgFlag;
    logic supChgEn;
    logic lineChgFlag;
    logic lineChgEn;
    logic faultFlag;
    logic faultEn;
    logic [7:0] xcvr;
    logic powerEn;
    logic [3:0] hostCode;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] prevB;
    logic [1:0] warm;
  } state_t;

  localparam state_t ST_RST = '{xcvr: XCVR_RST, hostCode: CODE_RST, syncA: PIN_RST,
                                syncB: PIN_RST, prevB: PIN_RST, default: '0};

  state_t st;
  state_t next_st;

  logic [3:0] pinsRaw;
  logic [3:0] pinChg;
  logic warmOk;
  logic supEvt;
  logic lineEvt;
  logic faultEvt;
  logic devSum;
  logic hostSum;
  logic actRole;
  logic fnActive;
  logic doWrite;
  logic wEn;
  logic wrOk;
  logic supClr;
  logic lineClr;
  logic faultClr;
  logic [31:0] rdVal;
  logic rdOk;

  assign pinsRaw = {dmPin, dpPin, faultPin_n, supplySensePin};

  // ----------------------------------------------------------------
  // Port watch events
  // ----------------------------------------------------------------
  assign pinChg = st.syncB ^ st.prevB;
  assign warmOk = (st.warm == WARM_DONE);
  // Detection runs in every power state and either role
  assign supEvt = warmOk & pinChg[PIN_SENSE];
  assign lineEvt = warmOk & (pinChg[PIN_DP] | pinChg[PIN_DM]);
  assign faultEvt = warmOk & st.prevB[PIN_FAULT_N] & ~st.syncB[PIN_FAULT_N];

  // ----------------------------------------------------------------
  // Summaries and role
  // ----------------------------------------------------------------
  assign devSum = st.supChgFlag & st.supChgEn;
  assign hostSum = (st.lineChgFlag & st.lineChgEn) | (st.faultFlag & st.faultEn);

  always_comb begin
    if (st.portCount) begin
      actRole = st.mapSel;
      fnActive = 1'b1;
    end else begin
      case (pmState)
        PERIPH_ACTIVE_ST: begin
          actRole = 1'b0;
          fnActive = 1'b1;
        end
        HOSTSIDE_ACTIVE_ST: begin
          actRole = 1'b1;
          fnActive = 1'b1;
        end
        BOTH_ACTIVE_ST: begin
          actRole = bothEntryHost;
          fnActive = 1'b1;
        end
        default: begin
          actRole = 1'b0;
          fnActive = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    case (araddr)
      ROLE_SEL_OFS: begin
        rdVal[MAP_SEL_BIT] = st.mapSel;
        rdVal[PORT_CNT_BIT] = st.portCount;
      end
      PM_MON_OFS: rdVal[ACT_ROLE_BIT] = actRole;
      TOP_STAT_OFS: begin
        rdVal[DEV_SUM_BIT] = devSum;
        rdVal[HOST_SUM_BIT] = hostSum;
      end
      TOP_EN_OFS: rdVal[1:0] = st.topEn;
      // Device-only registers need the device map
      PERI_STAT_OFS: begin
        rdVal[SUP_CHG_BIT] = st.supChgFlag;
        rdOk = ~st.mapSel;
      end
      PERI_EN_OFS: begin
        rdVal[SUP_CHG_BIT] = st.supChgEn;
        rdOk = ~st.mapSel;
      end
      PERI_USB_OFS: begin
        rdVal[SENSE_BIT] = st.syncB[PIN_SENSE];
        rdOk = ~st.mapSel;
      end
      // Host-only registers need the host map
      HOST_STAT_OFS: begin
        rdVal[LINE_CHG_BIT] = st.lineChgFlag;
        rdVal[FAULT_BIT] = st.faultFlag;
        rdOk = st.mapSel;
      end
      HOST_EN_OFS: begin
        rdVal[LINE_CHG_BIT] = st.lineChgEn;
        rdVal[FAULT_BIT] = st.faultEn;
        rdOk = st.mapSel;
      end
      HOST_XCVR_OFS: begin
        rdVal[7:0] = st.xcvr;
        rdOk = st.mapSel;
      end
      HOST_USBCTL_OFS: begin
        rdVal[PWR_EN_BIT] = st.powerEn;
        rdOk = st.mapSel;
      end
      HOST_USBSTAT_OFS: begin
        rdVal[1:0] = {st.syncB[PIN_DP], st.syncB[PIN_DM]};
        rdVal[FAULT_LVL_BIT] = ~st.syncB[PIN_FAULT_N];
        rdOk = st.mapSel;
      end
      HOST_NEGO_OFS: begin
        rdVal[3:0] = st.hostCode;
        rdOk = st.mapSel;
      end
      default: rdOk = 1'b0;
    endcase
    if (!rdOk) begin
      rdVal = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Write decode and next state
  // ----------------------------------------------------------------
  assign doWrite = st.awHeld & st.wHeld & ~st.bValid;
  assign wEn = doWrite & st.wStrb[0];

  always_comb begin
    next_st = st;
    wrOk = 1'b1;
    supClr = 1'b0;
    lineClr = 1'b0;
    faultClr = 1'b0;

    // Two-flop synchronisers, then a history stage for edges
    next_st.syncA = pinsRaw;
    next_st.syncB = st.syncA;
    next_st.prevB = st.syncB;
    if (!warmOk) begin
      next_st.warm = st.warm + 2'h1;
    end

    // Address and data are taken in either order
    if (awvalid && awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bValid && bready) begin
      next_st.bValid = 1'b0;
    end

    if (doWrite) begin
      case (st.awAddr)
        // Accepted in every power state
        ROLE_SEL_OFS: if (wEn) begin
          next_st.mapSel = st.wData[MAP_SEL_BIT];
          next_st.portCount = st.wData[PORT_CNT_BIT];
        end
        PM_MON_OFS, TOP_STAT_OFS: wrOk = 1'b1;
        TOP_EN_OFS: if (wEn) begin
          next_st.topEn = st.wData[1:0];
        end
        PERI_STAT_OFS: begin
          wrOk = ~st.mapSel;
          supClr = wEn & ~st.mapSel & st.wData[SUP_CHG_BIT];
        end
        PERI_EN_OFS: begin
          wrOk = ~st.mapSel;
          if (wEn && !st.mapSel) begin
            next_st.supChgEn = st.wData[SUP_CHG_BIT];
          end
        end
        PERI_USB_OFS: wrOk = ~st.mapSel;
        HOST_STAT_OFS: begin
          wrOk = st.mapSel;
          lineClr = wEn & st.mapSel & st.wData[LINE_CHG_BIT];
          faultClr = wEn & st.mapSel & st.wData[FAULT_BIT];
        end
        HOST_EN_OFS: begin
          wrOk = st.mapSel;
          if (wEn && st.mapSel) begin
            next_st.lineChgEn = st.wData[LINE_CHG_BIT];
            next_st.faultEn = st.wData[FAULT_BIT];
          end
        end
        HOST_XCVR_OFS: begin
          wrOk = st.mapSel;
          if (wEn && st.mapSel) begin
            next_st.xcvr = st.wData[7:0];
          end
        end
        HOST_USBCTL_OFS: begin
          wrOk = st.mapSel;
          if (wEn && st.mapSel) begin
            next_st.powerEn = st.wData[PWR_EN_BIT];
          end
        end
        HOST_USBSTAT_OFS: wrOk = st.mapSel;
        HOST_NEGO_OFS: begin
          wrOk = st.mapSel;
          if (wEn && st.mapSel) begin
            next_st.hostCode = st.wData[3:0];
            // In the host role a nonzero code retunes transceiver mode bits [1:0] and power
            if (actRole && st.wData[3:0] != CODE_RST) begin
              next_st.xcvr = {st.xcvr[7:2], st.wData[1:0]};
              next_st.powerEn = st.wData[3];
            end
          end
        end
        default: wrOk = 1'b0;
      endcase
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = wrOk ? RESP_OKAY : RESP_SLVERR;
    end

    // Sticky flags: write one clears, a new event wins
    next_st.supChgFlag = (st.supChgFlag & ~supClr) | supEvt;
    next_st.lineChgFlag = (st.lineChgFlag & ~lineClr) | lineEvt;
    next_st.faultFlag = (st.faultFlag & ~faultClr) | faultEvt;

    // Read channel
    if (arvalid && arready) begin
      next_st.rValid = 1'b1;
      next_st.rData = rdVal;
      next_st.rResp = rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = ~st.awHeld;
  assign wready = ~st.wHeld;
  assign bvalid = st.bValid;
  assign bresp = st.bResp;
  assign arready = ~st.rValid;
  assign rvalid = st.rValid;
  assign rdata = st.rData;
  assign rresp = st.rResp;
  assign hostPowerEnable = st.powerEn;
  assign hostXcvrCtrl = st.xcvr;
  assign transceiverOpField = st.xcvr[1:0];
  assign roleMapSelect = st.mapSel;
  assign portCountSelect = st.portCount;
  assign activeRoleMonitor = actRole;
  assign deviceFunctionEnable = fnActive & ~actRole;
  assign hostFunctionEnable = fnActive & actRole;
  assign deviceIrqSummary = devSum;
  assign hostIrqSummary = hostSum;
  assign mainIrq = (devSum & st.topEn[DEV_SUM_BIT]) | (hostSum & st.topEn[HOST_SUM_BIT]);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_roleWrite;
    ce && wEn && st.awAddr == ROLE_SEL_OFS;
  endsequence

  sequence s_pwrOn;
    ce && wEn && st.mapSel && st.awAddr == HOST_USBCTL_OFS && st.wData[PWR_EN_BIT];
  endsequence

  property p_mapHost;
    @(posedge ref_clk) disable iff (!rst_n)
    s_roleWrite and st.wData[MAP_SEL_BIT] |=> roleMapSelect;
  endproperty
  a_mapHost: assert property (p_mapHost) else $error("map select not set");

  property p_periGuard;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && arvalid && arready && st.mapSel && araddr == PERI_STAT_OFS |=> rvalid && rresp == RESP_SLVERR;
  endproperty
  a_periGuard: assert property (p_periGuard) else $error("device register open under host map");

  property p_twoPortHost;
    @(posedge ref_clk) disable iff (!rst_n)
    !portCountSelect && pmState == HOSTSIDE_ACTIVE_ST |-> activeRoleMonitor && hostFunctionEnable;
  endproperty
  a_twoPortHost: assert property (p_twoPortHost) else $error("host state without host function");

  property p_bothRole;
    @(posedge ref_clk) disable iff (!rst_n)
    !portCountSelect && pmState == BOTH_ACTIVE_ST |-> activeRoleMonitor == bothEntryHost;
  endproperty
  a_bothRole: assert property (p_bothRole) else $error("monitor wrong in both-active");

  property p_onePort;
    @(posedge ref_clk) disable iff (!rst_n)
    portCountSelect |-> activeRoleMonitor == roleMapSelect && deviceFunctionEnable == !roleMapSelect;
  endproperty
  a_onePort: assert property (p_onePort) else $error("1-port function mismatch");

  property p_supSet;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && supEvt |=> st.supChgFlag;
  endproperty
  a_supSet: assert property (p_supSet) else $error("supply change flag missed");

  property p_devSum;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && supEvt ##1 st.supChgEn |-> deviceIrqSummary;
  endproperty
  a_devSum: assert property (p_devSum) else $error("device summary not raised");

  property p_lineSet;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && warmOk && (pinChg[PIN_DP] || pinChg[PIN_DM]) |=> st.lineChgFlag;
  endproperty
  a_lineSet: assert property (p_lineSet) else $error("line change flag missed");

  property p_faultSet;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && faultEvt ##1 st.faultEn |-> hostIrqSummary;
  endproperty
  a_faultSet: assert property (p_faultSet) else $error("fault not summarised");

  property p_pwrPin;
    @(posedge ref_clk) disable iff (!rst_n)
    s_pwrOn |=> hostPowerEnable;
  endproperty
  a_pwrPin: assert property (p_pwrPin) else $error("power pin not driven");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_n)
    st.lineChgFlag && !(ce && lineClr) |=> st.lineChgFlag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("line flag dropped without clear");

  property p_wrResp;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && doWrite |=> bvalid ##0 !awready == 1'b0;
  endproperty
  a_wrResp: assert property (p_wrResp) else $error("write response missing");

endmodule

// file: bench/usb_cable_model.sv
// Cable and power switch model at the USB port pins
// Assumes the bench sets attach and overcurrent controls
`timescale 1ns/1ps
module usb_cable_model (
  // Controls
  input wire logic hostAttach,
  input wire logic periphAttach,
  input wire logic lowSpeedAttach,
  input wire logic overCurrent,
  // Port pins
  input wire logic powerOn,
  output logic supplySensePin,
  output logic faultPin_n,
  output logic dpPin,
  output logic dmPin
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Bus power present while a host or hub is attached
  assign supplySensePin = hostAttach;
  // Switch flags a fault only while driving power; pull-up otherwise
  assign faultPin_n = !(powerOn && overCurrent);
  // Full-speed attach pulls D+ up, low-speed attach pulls D- up, SE0 otherwise
  assign dpPin = periphAttach;
  assign dmPin = lowSpeedAttach;
endmodule

// file: bench/test_usb_role_select_port_watch.sv
// Self-checking bench for the role select and port watch block
// Assumes one 125 MHz clock and the cable model on the port pins
`timescale 1ns/1ps
module test_usb_role_select_port_watch;
  import usb_role_select_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pm_state_t pmState = SLEEP_ST;
  logic bothEntryHost = 1'b0;
  logic hostAttach = 1'b0, periphAttach = 1'b0, lowSpeedAttach = 1'b0, overCurrent = 1'b0;
  logic supplySensePin, faultPin_n, dpPin, dmPin, hostPowerEnable;
  logic [7:0] hostXcvrCtrl;
  logic [1:0] transceiverOpField;
  logic roleMapSelect, portCountSelect, activeRoleMonitor;
  logic deviceFunctionEnable, hostFunctionEnable, deviceIrqSummary, hostIrqSummary, mainIrq;
  int mismatches = 0;
  int totalChecks = 0;
  pm_state_t fnState [5] = '{SLEEP_ST, PERIPH_ACTIVE_ST, HOSTSIDE_ACTIVE_ST, BOTH_ACTIVE_ST, BOTH_ACTIVE_ST};
  logic fnBoth [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [1:0] fnExp [5] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h1};

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Design and cable
  // ----------------------------------------------------------------
  usb_role_select_port_watch u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pmState(pmState), .bothEntryHost(bothEntryHost),
    .supplySensePin(supplySensePin), .faultPin_n(faultPin_n), .dpPin(dpPin), .dmPin(dmPin),
    .hostPowerEnable(hostPowerEnable), .hostXcvrCtrl(hostXcvrCtrl), .transceiverOpField(transceiverOpField),
    .roleMapSelect(roleMapSelect), .portCountSelect(portCountSelect), .activeRoleMonitor(activeRoleMonitor),
    .deviceFunctionEnable(deviceFunctionEnable), .hostFunctionEnable(hostFunctionEnable),
    .deviceIrqSummary(deviceIrqSummary), .hostIrqSummary(hostIrqSummary), .mainIrq(mainIrq)
  );

  usb_cable_model u_cable (
    .hostAttach(hostAttach), .periphAttach(periphAttach), .lowSpeedAttach(lowSpeedAttach),
    .overCurrent(overCurrent),
    .powerOn(hostPowerEnable), .supplySensePin(supplySensePin), .faultPin_n(faultPin_n),
    .dpPin(dpPin), .dmPin(dmPin)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic bV;
    logic [1:0] resp;
    bV = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bV) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bV = bvalid;
      resp = bresp;
    end
    bready <= 1'b0;
    @(posedge ref_clk);
    chk({bV, resp}, {1'b1, er});
  endtask

  task automatic axRead(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic rV;
    logic [31:0] d;
    logic [1:0] resp;
    rV = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rV) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      rV = rvalid;
      d = rdata;
      resp = rresp;
    end
    rready <= 1'b0;
    @(posedge ref_clk);
    chk(d, ed);
    chk({rV, resp}, {1'b1, er});
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    axRead(ROLE_SEL_OFS, 32'h0000_0000, RESP_OKAY);
    axRead(8'h3C, 32'h0000_0000, RESP_SLVERR);
    for (int s = 0; s < 6; s++) begin
      pmState <= pm_state_t'(s);
      axWrite(ROLE_SEL_OFS, 32'h0000_0001, RESP_OKAY);
      chk(roleMapSelect, 32'h0000_0001);
      axRead(HOST_EN_OFS, 32'h0000_0000, RESP_OKAY);
      axRead(PERI_EN_OFS, 32'h0000_0000, RESP_SLVERR);
      axWrite(ROLE_SEL_OFS, 32'h0000_0000, RESP_OKAY);
      axRead(HOST_EN_OFS, 32'h0000_0000, RESP_SLVERR);
      axRead(TOP_EN_OFS, 32'h0000_0000, RESP_OKAY);
    end
    for (int i = 0; i < 5; i++) begin
      pmState <= fnState[i];
      bothEntryHost <= fnBoth[i];
      cycles(2);
      chk({deviceFunctionEnable, hostFunctionEnable}, fnExp[i]);
      if (i > 0) axRead(PM_MON_OFS, fnExp[i][0], RESP_OKAY);
    end
    pmState <= SLEEP_ST;
    axWrite(ROLE_SEL_OFS, 32'h0000_0002, RESP_OKAY);
    chk({activeRoleMonitor, deviceFunctionEnable, hostFunctionEnable}, 32'h0000_0002);
    axWrite(ROLE_SEL_OFS, 32'h0000_0003, RESP_OKAY);
    chk({activeRoleMonitor, deviceFunctionEnable, hostFunctionEnable}, 32'h0000_0005);
    axWrite(ROLE_SEL_OFS, 32'h0000_0000, RESP_OKAY);
    // Supply change watch in sleep, device map
    axWrite(PERI_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    axWrite(PERI_EN_OFS, 32'h0000_0001, RESP_OKAY);
    axWrite(TOP_EN_OFS, 32'h0000_0003, RESP_OKAY);
    hostAttach <= 1'b1;
    cycles(8);
    axRead(PERI_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    chk({deviceIrqSummary, mainIrq}, 32'h0000_0003);
    axRead(TOP_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    axRead(PERI_USB_OFS, 32'h0000_0001, RESP_OKAY);
    cycles(20);
    axRead(PERI_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    axWrite(PERI_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    axRead(PERI_STAT_OFS, 32'h0000_0000, RESP_OKAY);
    axWrite(PERI_EN_OFS, 32'h0000_0000, RESP_OKAY);
    hostAttach <= 1'b0;
    cycles(8);
    axRead(PERI_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    chk(deviceIrqSummary, 32'h0000_0000);
    axRead(PERI_USB_OFS, 32'h0000_0000, RESP_OKAY);
    // Line change and supply fault watch, host map
    axWrite(ROLE_SEL_OFS, 32'h0000_0001, RESP_OKAY);
    axWrite(HOST_STAT_OFS, 32'h0000_0003, RESP_OKAY);
    axWrite(HOST_EN_OFS, 32'h0000_0003, RESP_OKAY);
    axWrite(HOST_XCVR_OFS, 32'h0000_0093, RESP_OKAY);
    axWrite(HOST_USBCTL_OFS, 32'h0000_0001, RESP_OKAY);
    chk({hostPowerEnable, hostXcvrCtrl, transceiverOpField}, 32'h0000_064F);
    periphAttach <= 1'b1;
    cycles(8);
    axRead(HOST_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    chk({hostIrqSummary, mainIrq}, 32'h0000_0003);
    axRead(HOST_USBSTAT_OFS, 32'h0000_0002, RESP_OKAY);
    axWrite(HOST_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    axWrite(HOST_EN_OFS, 32'h0000_0002, RESP_OKAY);
    chk(hostIrqSummary, 32'h0000_0000);
    overCurrent <= 1'b1;
    cycles(8);
    axRead(HOST_STAT_OFS, 32'h0000_0002, RESP_OKAY);
    chk(hostIrqSummary, 32'h0000_0001);
    axRead(HOST_USBSTAT_OFS, 32'h0000_0006, RESP_OKAY);
    axWrite(HOST_USBCTL_OFS, 32'h0000_0000, RESP_OKAY);
    chk(hostPowerEnable, 32'h0000_0000);
    cycles(8);
    axRead(HOST_USBSTAT_OFS, 32'h0000_0002, RESP_OKAY);
    axRead(HOST_STAT_OFS, 32'h0000_0002, RESP_OKAY);
    axWrite(HOST_STAT_OFS, 32'h0000_0002, RESP_OKAY);
    overCurrent <= 1'b0;
    // Host code updates transceiver and power after host selection
    pmState <= HOSTSIDE_ACTIVE_ST;
    axRead(HOST_XCVR_OFS, 32'h0000_0093, RESP_OKAY);
    axWrite(HOST_NEGO_OFS, 32'h0000_0009, RESP_OKAY);
    chk({hostPowerEnable, hostXcvrCtrl}, 32'h0000_0191);
    axWrite(HOST_NEGO_OFS, 32'h0000_0000, RESP_OKAY);
    axRead(HOST_XCVR_OFS, 32'h0000_0091, RESP_OKAY);
    // Low-speed attach moves only D-
    periphAttach <= 1'b0;
    cycles(8);
    axWrite(HOST_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    lowSpeedAttach <= 1'b1;
    cycles(8);
    axRead(HOST_STAT_OFS, 32'h0000_0001, RESP_OKAY);
    axRead(HOST_USBSTAT_OFS, 32'h0000_0001, RESP_OKAY);
    finishTest();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    finishTest();
  end
endmodule
